// ===== hw/bhs_pkg.sv
package bhs_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int CLK_HZ = 200_000_000;
  localparam int HB_W = 27;
  localparam int HB_SLOW_HZ = 1;
  localparam int HB_FAST_HZ = 5;
  // Half periods, because the generator toggles once per half period.
  localparam logic [HB_W-1:0] HB_SLOW_HALF = HB_W'(CLK_HZ / (2 * HB_SLOW_HZ));
  localparam logic [HB_W-1:0] HB_FAST_HALF = HB_W'(CLK_HZ / (2 * HB_FAST_HZ));
  localparam int BLINK_SLOT_MS = 250;
  localparam logic [HB_W-1:0] BLINK_HALF = HB_W'((CLK_HZ / 1000) * BLINK_SLOT_MS);
  localparam logic [3:0] BLINK_GAP_SLOTS = 4'h4;

  // ********************************************************************
  // Debug serial port defaults
  // ********************************************************************
  localparam int UART_BAUD = 115200;
  localparam logic [15:0] UART_DIV = 16'(CLK_HZ / UART_BAUD);
  localparam logic [3:0] UART_DATA_BITS = 4'h8;
  localparam logic [1:0] UART_STOP_BITS = 2'h1;
  localparam logic UART_PARITY_EN = 1'b0;
  localparam logic UART_FLOW_EN = 1'b0;

  // ********************************************************************
  // Flash layout
  // ********************************************************************
  localparam int AW = 24;
  localparam logic [AW-1:0] LOADER_BASE = 24'h000000;
  localparam int LOADER_BYTES = 64;
  localparam logic [AW-1:0] MAIN_HDR_ADDR = 24'h010000;
  localparam logic [7:0] MAIN_MARK = 8'hA5;
  localparam logic [AW-1:0] SECTOR_MASK = 24'hFFF000;
  localparam logic [8:0] FLASH_TIMEOUT = 9'h100;

  // ********************************************************************
  // Host commands, modes and exception codes
  // ********************************************************************
  localparam logic [3:0] CMD_GET_MODE = 4'h1;
  localparam logic [3:0] CMD_SWITCH_MODE = 4'h2;
  localparam logic [3:0] CMD_UNLOCK = 4'h3;
  localparam logic [3:0] CMD_LOCK = 4'h4;
  localparam logic [3:0] CMD_ERASE = 4'h5;
  localparam logic [3:0] CMD_PROGRAM = 4'h6;
  localparam logic [3:0] CMD_CHECKSUM = 4'h7;
  localparam logic [3:0] CMD_DBG_ROUTE = 4'h8;
  localparam logic [3:0] CMD_GET_RAM = 4'h9;
  localparam logic MODE_LOADER = 1'b0;
  localparam logic MODE_MAIN = 1'b1;
  localparam logic [1:0] EXC_DATA = 2'h1;
  localparam logic [1:0] EXC_PREFETCH = 2'h2;
  localparam logic [1:0] EXC_UNDEF = 2'h3;

  typedef enum logic [2:0] {
    S_COPY, S_CHECK, S_IDLE, S_SUM, S_SUMOUT, S_ERASE, S_PROG, S_EXC
  } bhs_state_e;

endpackage : bhs_pkg

// ===== hw/bhs_toggle_gen.sv
`timescale 1ns/1ps
module bhs_toggle_gen #(
  parameter int W = bhs_pkg::HB_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [W-1:0] half_cnt,
  output logic wave,
  output logic tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic wave_next;
  logic tick_next;

  // Divide by a runtime half period; >= keeps a shortened period safe.
  always_comb begin
    cnt_next = cnt_reg;
    wave_next = wave;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = '0;
      wave_next = 1'b0;
    end else if (cnt_reg >= half_cnt - W'(1)) begin
      cnt_next = '0;
      wave_next = ~wave;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + W'(1);
    end
  end

  // Registers only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      wave <= 1'b0;
      tick <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      wave <= wave_next;
      tick <= tick_next;
    end
  end

  toggle_edge_a: assert property ((run && ce && cnt_reg >= half_cnt - W'(1)) |=>
    (wave != $past(wave) && tick)) else $error("wave did not toggle at end of half period");
  idle_low_a: assert property ((!run && ce) |=> !wave)
    else $error("wave not low while stopped");

endmodule : bhs_toggle_gen

// ===== hw/bhs_checksum.sv
`timescale 1ns/1ps
module bhs_checksum (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic add,
  input wire logic [7:0] data,
  output logic [31:0] sum
);
  logic [31:0] sum_next;

  // Plain additive sum of bytes; clear wins so a new request starts clean.
  always_comb begin
    sum_next = sum;
    if (clr) begin
      sum_next = '0;
    end else if (add) begin
      sum_next = sum + {24'h0, data};
    end
  end

  // Registers only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum <= '0;
    end else if (ce) begin
      sum <= sum_next;
    end
  end

endmodule : bhs_checksum

// ===== hw/bhs_top.sv
`timescale 1ns/1ps
// Behaviour
// - No internal boot store; code comes from flash.
// - Loader runs first, copying itself into RAM.
// - Main image starts only once found valid.
// - Boot-hold low at startup keeps loader mode.
// - Erase and program refused while flash locked.
// - Sector erase touches only the given sector.
// - Checksum over host start address and count.
// - Open-drain busy line shows free or busy.
// - Heartbeat 1 Hz square after good boot into main mode.
// - Heartbeat 5 Hz square on detected error in main mode.
// - Startup error: loader mode, fault LED high.
// - Processor exception blinks fault LED code.
// - Exception fault state ignores host commands.
// - Debug UART defaults 115200 8N1, no flow.
// - Report mode and switch mode on command.
// - Debug output redirected to USB on command.
module bhs_top #(
  parameter logic [bhs_pkg::HB_W-1:0] HB_SLOW_HALF = bhs_pkg::HB_SLOW_HALF,
  parameter logic [bhs_pkg::HB_W-1:0] HB_FAST_HALF = bhs_pkg::HB_FAST_HALF,
  parameter logic [bhs_pkg::HB_W-1:0] BLINK_HALF = bhs_pkg::BLINK_HALF,
  parameter int LOADER_BYTES = bhs_pkg::LOADER_BYTES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic stay_in_loader_n,
  input wire logic err_detect,
  input wire logic exc_data_abort,
  input wire logic exc_prefetch_abort,
  input wire logic exc_undef_instr,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [23:0] cmd_addr,
  input wire logic [23:0] cmd_count,
  input wire logic [7:0] cmd_data,
  output logic resp_valid,
  output logic resp_err,
  output logic [31:0] resp_data,
  input wire logic host_busy_i,
  output logic host_busy_o,
  output logic host_busy_oe,
  output logic primary_flash_select_n,
  output logic [23:0] flash_addr,
  output logic flash_read,
  output logic flash_erase,
  output logic flash_program,
  output logic [7:0] flash_wdata,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_ack,
  output logic heartbeat,
  output logic fault_led,
  output logic dbg_to_usb,
  output logic [15:0] uart_baud_div,
  output logic [3:0] uart_data_bits,
  output logic uart_parity_en,
  output logic [1:0] uart_stop_bits,
  output logic uart_flow_en
);
  localparam int IDX_W = $clog2(LOADER_BYTES);
  localparam logic [23:0] COPY_LAST = bhs_pkg::LOADER_BASE + 24'(LOADER_BYTES - 1);

  // ********************************************************************
  // Reset release
  // ********************************************************************
  logic rst_meta_reg;
  logic rst_q;

  // Assert at once, release through two flops so no flop sees a runt edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_q <= rst_meta_reg;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_q);

  // ********************************************************************
  // State
  // ********************************************************************
  bhs_pkg::bhs_state_e state_reg, state_next;
  logic [23:0] addr_reg, addr_next;
  logic [23:0] count_reg, count_next;
  logic [8:0] tmo_reg, tmo_next;
  logic mode_reg, mode_next;
  logic image_ok_reg, image_ok_next;
  logic boot_fault_reg, boot_fault_next;
  logic hold_reg, hold_next;
  logic sampled_reg, sampled_next;
  logic unlocked_reg, unlocked_next;
  logic usb_next;
  logic read_next, erase_next, prog_next, cs_n_next;
  logic [7:0] wdata_next;
  logic rv_next, re_next;
  logic [31:0] rd_next;
  logic oe_next;
  logic [1:0] exc_code_reg, exc_code_next;
  logic [3:0] slot_reg, slot_next;
  logic [3:0] period;
  logic led_next;
  logic ram_we, sum_clr, sum_add, tmo_hit, exc_any, blink_tick;
  logic [31:0] sum_val;
  logic [7:0] loader_ram [LOADER_BYTES];

  assign exc_any = exc_data_abort | exc_prefetch_abort | exc_undef_instr;
  assign flash_addr = addr_reg; // The address port comes straight from its flop.
  assign period = {1'b0, exc_code_reg, 1'b0} + bhs_pkg::BLINK_GAP_SLOTS;

  // ********************************************************************
  // Sub-blocks
  // ********************************************************************
  bhs_toggle_gen #(.W(bhs_pkg::HB_W)) u_heartbeat (
    .clk(clk_sys),
    .rst_n(rst_q),
    .ce(clk_en),
    .run(mode_reg == bhs_pkg::MODE_MAIN && state_reg != bhs_pkg::S_EXC),
    .half_cnt(err_detect ? HB_FAST_HALF : HB_SLOW_HALF),
    .wave(heartbeat),
    .tick()
  );

  bhs_toggle_gen #(.W(bhs_pkg::HB_W)) u_blink (
    .clk(clk_sys),
    .rst_n(rst_q),
    .ce(clk_en),
    .run(state_reg == bhs_pkg::S_EXC),
    .half_cnt(BLINK_HALF),
    .wave(),
    .tick(blink_tick)
  );

  bhs_checksum u_sum (
    .clk(clk_sys),
    .rst_n(rst_q),
    .ce(clk_en),
    .clr(sum_clr),
    .add(sum_add),
    .data(flash_rdata),
    .sum(sum_val)
  );

  // ********************************************************************
  // Sequencer: boot, host commands, exception fault
  // ********************************************************************
  // Next values for the whole sequencer; an exception overrides the per-state logic, not strap capture or the timeout count.
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    count_next = count_reg;
    mode_next = mode_reg;
    image_ok_next = image_ok_reg;
    boot_fault_next = boot_fault_reg;
    hold_next = hold_reg;
    sampled_next = 1'b1;
    unlocked_next = unlocked_reg;
    usb_next = dbg_to_usb;
    read_next = flash_read;
    erase_next = flash_erase;
    prog_next = flash_program;
    cs_n_next = primary_flash_select_n;
    wdata_next = flash_wdata;
    rv_next = 1'b0;
    re_next = 1'b0;
    rd_next = resp_data;
    exc_code_next = exc_code_reg;
    slot_next = slot_reg;
    led_next = fault_led;
    ram_we = 1'b0;
    sum_clr = 1'b0;
    sum_add = 1'b0;
    // Strap is caught once, on the first enabled edge after release.
    if (!sampled_reg) begin
      hold_next = ~stay_in_loader_n;
    end
    tmo_next = '0;
    if (flash_read | flash_erase | flash_program) begin
      tmo_next = flash_ack ? 9'h000 : tmo_reg + 9'h001;
    end
    tmo_hit = (flash_read | flash_erase | flash_program) && !flash_ack &&
              (tmo_reg == bhs_pkg::FLASH_TIMEOUT - 9'h001);
    if (exc_any && state_reg != bhs_pkg::S_EXC) begin
      state_next = bhs_pkg::S_EXC;
      exc_code_next = exc_data_abort ? bhs_pkg::EXC_DATA :
                      exc_prefetch_abort ? bhs_pkg::EXC_PREFETCH : bhs_pkg::EXC_UNDEF;
      slot_next = 4'h0;
      led_next = 1'b1;
      read_next = 1'b0;
      erase_next = 1'b0;
      prog_next = 1'b0;
      cs_n_next = 1'b1;
    end else begin
      unique case (state_reg)
        bhs_pkg::S_COPY: begin
          // Only the external flash holds code; the loader copies itself first.
          read_next = 1'b1;
          cs_n_next = 1'b0;
          if (tmo_hit) begin
            boot_fault_next = 1'b1;
            state_next = bhs_pkg::S_IDLE;
            read_next = 1'b0;
            cs_n_next = 1'b1;
          end else if (flash_ack) begin
            ram_we = 1'b1;
            if (addr_reg == COPY_LAST) begin
              addr_next = bhs_pkg::MAIN_HDR_ADDR;
              state_next = bhs_pkg::S_CHECK;
            end else begin
              addr_next = addr_reg + 24'h000001;
            end
          end
        end
        bhs_pkg::S_CHECK: begin
          if (tmo_hit || flash_ack) begin
            read_next = 1'b0;
            cs_n_next = 1'b1;
            state_next = bhs_pkg::S_IDLE;
            image_ok_next = flash_ack && flash_rdata == bhs_pkg::MAIN_MARK;
            if (!(flash_ack && flash_rdata == bhs_pkg::MAIN_MARK)) begin
              boot_fault_next = 1'b1;
            end else if (!hold_reg) begin
              mode_next = bhs_pkg::MODE_MAIN;
            end
          end
        end
        bhs_pkg::S_IDLE: begin
          if (cmd_valid) begin
            rv_next = 1'b1;
            rd_next = '0;
            unique case (cmd_code)
              bhs_pkg::CMD_GET_MODE: rd_next = {31'h0, mode_reg};
              bhs_pkg::CMD_SWITCH_MODE: begin
                if (cmd_data[0] == bhs_pkg::MODE_MAIN && !image_ok_reg) begin
                  re_next = 1'b1;
                end else begin
                  mode_next = cmd_data[0];
                end
              end
              bhs_pkg::CMD_UNLOCK: unlocked_next = 1'b1;
              bhs_pkg::CMD_LOCK: unlocked_next = 1'b0;
              bhs_pkg::CMD_ERASE, bhs_pkg::CMD_PROGRAM: begin
                if (!unlocked_reg || mode_reg != bhs_pkg::MODE_LOADER) begin
                  re_next = 1'b1;
                end else begin
                  rv_next = 1'b0;
                  cs_n_next = 1'b0;
                  wdata_next = cmd_data;
                  if (cmd_code == bhs_pkg::CMD_ERASE) begin
                    addr_next = cmd_addr & bhs_pkg::SECTOR_MASK;
                    erase_next = 1'b1;
                    state_next = bhs_pkg::S_ERASE;
                  end else begin
                    addr_next = cmd_addr;
                    prog_next = 1'b1;
                    state_next = bhs_pkg::S_PROG;
                  end
                end
              end
              bhs_pkg::CMD_CHECKSUM: begin
                sum_clr = 1'b1;
                if (cmd_count != 24'h000000) begin
                  rv_next = 1'b0;
                  addr_next = cmd_addr;
                  count_next = cmd_count;
                  read_next = 1'b1;
                  cs_n_next = 1'b0;
                  state_next = bhs_pkg::S_SUM;
                end
              end
              bhs_pkg::CMD_DBG_ROUTE: usb_next = cmd_data[0];
              bhs_pkg::CMD_GET_RAM: rd_next = {24'h0, loader_ram[cmd_addr[IDX_W-1:0]]};
              default: re_next = 1'b1;
            endcase
          end
        end
        bhs_pkg::S_SUM: begin
          if (tmo_hit) begin
            read_next = 1'b0;
            cs_n_next = 1'b1;
            rv_next = 1'b1;
            re_next = 1'b1;
            state_next = bhs_pkg::S_IDLE;
          end else if (flash_ack) begin
            sum_add = 1'b1;
            addr_next = addr_reg + 24'h000001;
            count_next = count_reg - 24'h000001;
            if (count_reg == 24'h000001) begin
              read_next = 1'b0;
              cs_n_next = 1'b1;
              state_next = bhs_pkg::S_SUMOUT;
            end
          end
        end
        bhs_pkg::S_SUMOUT: begin
          rv_next = 1'b1;
          rd_next = sum_val;
          state_next = bhs_pkg::S_IDLE;
        end
        bhs_pkg::S_ERASE, bhs_pkg::S_PROG: begin
          if (tmo_hit || flash_ack) begin
            erase_next = 1'b0;
            prog_next = 1'b0;
            cs_n_next = 1'b1;
            rv_next = 1'b1;
            re_next = tmo_hit;
            state_next = bhs_pkg::S_IDLE;
          end
        end
        bhs_pkg::S_EXC: begin
          // Stays here until reset; the host side is deliberately dead.
          if (blink_tick) begin
            slot_next = (slot_reg == period - 4'h1) ? 4'h0 : slot_reg + 4'h1;
            led_next = (slot_next < {1'b0, exc_code_reg, 1'b0}) && !slot_next[0];
          end
        end
      endcase
    end
    if (state_next != bhs_pkg::S_EXC) begin
      led_next = boot_fault_next;
    end
    // Pin driven low only when ready; released (pulled high) otherwise.
    oe_next = (state_next == bhs_pkg::S_IDLE);
  end

  // Registers only; clk_en freezes everything.
  always_ff @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      state_reg <= bhs_pkg::S_COPY;
      addr_reg <= bhs_pkg::LOADER_BASE;
      count_reg <= '0;
      tmo_reg <= '0;
      mode_reg <= bhs_pkg::MODE_LOADER;
      image_ok_reg <= 1'b0;
      boot_fault_reg <= 1'b0;
      hold_reg <= 1'b0;
      sampled_reg <= 1'b0;
      unlocked_reg <= 1'b0;
      dbg_to_usb <= 1'b0;
      flash_read <= 1'b0;
      flash_erase <= 1'b0;
      flash_program <= 1'b0;
      primary_flash_select_n <= 1'b1;
      flash_wdata <= '0;
      resp_valid <= 1'b0;
      resp_err <= 1'b0;
      resp_data <= '0;
      host_busy_oe <= 1'b0;
      host_busy_o <= 1'b0;
      exc_code_reg <= '0;
      slot_reg <= '0;
      fault_led <= 1'b0;
      uart_baud_div <= bhs_pkg::UART_DIV;
      uart_data_bits <= bhs_pkg::UART_DATA_BITS;
      uart_parity_en <= bhs_pkg::UART_PARITY_EN;
      uart_stop_bits <= bhs_pkg::UART_STOP_BITS;
      uart_flow_en <= bhs_pkg::UART_FLOW_EN;
    end else if (clk_en) begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      count_reg <= count_next;
      tmo_reg <= tmo_next;
      mode_reg <= mode_next;
      image_ok_reg <= image_ok_next;
      boot_fault_reg <= boot_fault_next;
      hold_reg <= hold_next;
      sampled_reg <= sampled_next;
      unlocked_reg <= unlocked_next;
      dbg_to_usb <= usb_next;
      flash_read <= read_next;
      flash_erase <= erase_next;
      flash_program <= prog_next;
      primary_flash_select_n <= cs_n_next;
      flash_wdata <= wdata_next;
      resp_valid <= rv_next;
      resp_err <= re_next;
      resp_data <= rd_next;
      host_busy_oe <= oe_next;
      exc_code_reg <= exc_code_next;
      slot_reg <= slot_next;
      fault_led <= led_next;
    end
  end

  // Loader image store; no reset, contents are only valid after the copy.
  always_ff @(posedge clk_sys) begin
    if (clk_en && ram_we) begin
      loader_ram[addr_reg[IDX_W-1:0]] <= flash_rdata;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  copy_first_a: assert property ((state_reg == bhs_pkg::S_CHECK) |->
    ($past(state_reg) == bhs_pkg::S_COPY || $past(state_reg) == bhs_pkg::S_CHECK))
    else $error("image check entered without loader copy");
  main_valid_a: assert property ((mode_reg == bhs_pkg::MODE_MAIN) |-> image_ok_reg)
    else $error("main mode without a valid image");
  hold_loader_a: assert property ((state_reg == bhs_pkg::S_CHECK && clk_en && flash_ack &&
    hold_reg && !exc_any) |=> (mode_reg == bhs_pkg::MODE_LOADER && state_reg == bhs_pkg::S_IDLE))
    else $error("boot hold did not keep loader mode");
  lock_refuse_a: assert property ((state_reg == bhs_pkg::S_IDLE && clk_en && cmd_valid &&
    !exc_any && !unlocked_reg && (cmd_code == bhs_pkg::CMD_ERASE ||
    cmd_code == bhs_pkg::CMD_PROGRAM)) |=> (resp_valid && resp_err && !flash_erase &&
    !flash_program)) else $error("locked flash accepted erase or program");
  sector_align_a: assert property (flash_erase |->
    ((flash_addr & ~bhs_pkg::SECTOR_MASK) == 24'h000000 && !primary_flash_select_n))
    else $error("erase address not sector aligned");
  sum_result_a: assert property ((state_reg == bhs_pkg::S_SUMOUT && clk_en && !exc_any) |=>
    (resp_valid && !resp_err && resp_data == $past(sum_val)))
    else $error("checksum result not returned");
  busy_pin_a: assert property (host_busy_oe == (state_reg == bhs_pkg::S_IDLE) &&
    !host_busy_o) else $error("busy pin does not track readiness");
  boot_fault_a: assert property ((boot_fault_reg && state_reg != bhs_pkg::S_EXC) |->
    (fault_led && mode_reg == bhs_pkg::MODE_LOADER)) else $error("startup fault not flagged");
  exc_silent_a: assert property ((state_reg == bhs_pkg::S_EXC) |=>
    (!resp_valid && !host_busy_oe && state_reg == bhs_pkg::S_EXC))
    else $error("host answered during exception fault");
  uart_default_a: assert property ((uart_baud_div == bhs_pkg::UART_DIV) &&
    (uart_data_bits == bhs_pkg::UART_DATA_BITS) && !uart_parity_en && !uart_flow_en)
    else $error("debug port defaults lost");

endmodule : bhs_top

// ===== testbench/bhs_flash_model.sv
`timescale 1ns/1ps
// Flash on the first select; every request is answered one cycle late.
module bhs_flash_model (
  input wire logic clk,
  input wire logic sel_n,
  input wire logic rd,
  input wire logic er,
  input wire logic pr,
  input wire logic [23:0] addr,
  input wire logic img_ok,
  output logic [7:0] rdata,
  output logic ack,
  output logic [23:0] er_addr
);
  initial begin
    ack = 1'b0;
    rdata = 8'h00;
    er_addr = 24'h000000;
  end
  // Idle data flips every cycle so a stale byte never looks valid.
  always @(posedge clk) begin
    ack <= !sel_n && (rd || er || pr) && !ack;
    rdata <= ~rdata;
    if (!sel_n && rd && !ack) begin
      rdata <= (addr == bhs_pkg::MAIN_HDR_ADDR) ? (img_ok ? bhs_pkg::MAIN_MARK : 8'h00)
        : addr[7:0];
    end
    if (!sel_n && er && !ack) begin
      er_addr <= addr;
    end
  end
endmodule : bhs_flash_model

// ===== testbench/bhs_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module bhs_top_tb_top;
  logic clk_sys = 1'b0, rst_n = 1'b0, strap_n = 1'b1, err_det = 1'b0, img_ok = 1'b1, ce = 1'b1;
  logic cmd_valid = 1'b0, resp_valid, resp_err, busy_o, busy_oe, busy_line;
  logic [2:0] exc = 3'h0;
  logic [3:0] cmd_code = 4'h0, dbits;
  logic [23:0] cmd_addr = 24'h000000, cmd_count = 24'h000000, f_addr, er_addr;
  logic [7:0] cmd_data = 8'h00, f_wdata, f_rdata;
  logic [31:0] resp_data, rdat;
  logic sel_n, f_rd, f_er, f_pr, f_ack, hb, led, usb, par, flow, rerr;
  logic [15:0] baud;
  logic [1:0] stop;
  int n_mismatch = 0, samples_checked = 0;
  // Open-drain line with a pull-up.
  assign busy_line = busy_oe ? busy_o : 1'b1;
  always #2.5 clk_sys = ~clk_sys;
  bhs_top #(.HB_SLOW_HALF(27'h00000A), .HB_FAST_HALF(27'h000004),
    .BLINK_HALF(27'h000003), .LOADER_BYTES(4)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(ce), .stay_in_loader_n(strap_n), .err_detect(err_det),
    .exc_data_abort(exc[0]), .exc_prefetch_abort(exc[1]), .exc_undef_instr(exc[2]),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
    .cmd_count(cmd_count), .cmd_data(cmd_data), .resp_valid(resp_valid),
    .resp_err(resp_err), .resp_data(resp_data), .host_busy_i(busy_line),
    .host_busy_o(busy_o), .host_busy_oe(busy_oe), .primary_flash_select_n(sel_n),
    .flash_addr(f_addr), .flash_read(f_rd), .flash_erase(f_er), .flash_program(f_pr),
    .flash_wdata(f_wdata), .flash_rdata(f_rdata), .flash_ack(f_ack), .heartbeat(hb),
    .fault_led(led), .dbg_to_usb(usb), .uart_baud_div(baud), .uart_data_bits(dbits),
    .uart_parity_en(par), .uart_stop_bits(stop), .uart_flow_en(flow));
  bhs_flash_model u_flash (.clk(clk_sys), .sel_n(sel_n), .rd(f_rd), .er(f_er),
    .pr(f_pr), .addr(f_addr), .img_ok(img_ok), .rdata(f_rdata), .ack(f_ack),
    .er_addr(er_addr));
  // ******************************************************************
  // Tasks
  // ******************************************************************
  task end_sim;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // Resets with the given strap and image, then waits for the ready level.
  task boot(input logic s, input logic ok);
    int k;
    @(negedge clk_sys);
    rst_n = 1'b0;
    strap_n = s;
    img_ok = ok;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    k = 0;
    while (busy_line !== 1'b0 && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
    `CHK("ready", 1'b0, busy_line)
  endtask : boot
  // One command held for a single edge, then a bounded wait for its answer.
  task cmd(input logic [3:0] c, input logic [23:0] a, input logic [23:0] n,
      input logic [7:0] d);
    int k;
    @(negedge clk_sys);
    cmd_code = c;
    cmd_addr = a;
    cmd_count = n;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    k = 0;
    while (resp_valid !== 1'b1 && k < 600) begin
      @(negedge clk_sys);
      k++;
    end
    rdat = resp_data;
    rerr = resp_err;
    `CHK("resp", 1'b1, resp_valid)
  endtask : cmd
  // Measures one full half period of the heartbeat.
  task hb_half(input int e);
    int n;
    logic h;
    for (int i = 0; i < 2; i++) begin
      h = hb;
      n = 0;
      while (hb === h && n < 100) begin
        @(negedge clk_sys);
        n++;
      end
    end
    `CHK("hb_half", e, n)
  endtask : hb_half
  // Processor exception: blinking LED, busy released, host ignored.
  task exc_case;
    int n;
    @(negedge clk_sys);
    exc = 3'h1;
    repeat (2) @(negedge clk_sys);
    `CHK("exc_led", 1'b1, led)
    n = 0;
    while (led === 1'b1 && n < 30) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("blink", 1'b0, led)
    cmd_code = bhs_pkg::CMD_GET_MODE;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    repeat (10) @(negedge clk_sys) n += int'(resp_valid === 1'b1);
    `CHK("mute", 0, n)
    `CHK("busy", 1'b1, busy_line)
    exc = 3'h0;
  endtask : exc_case
  // ******************************************************************
  // Main sequence and watchdog
  // ******************************************************************
  initial begin
    boot(1'b1, 1'b1);
    `CHK("led", 1'b0, led)
    `CHK("uart", {bhs_pkg::UART_DIV, 4'h8, 1'b0, 2'h1, 1'b0}, {baud, dbits, par, stop, flow})
    cmd(bhs_pkg::CMD_GET_RAM, 24'h000002, 24'h000000, 8'h00);
    `CHK("ram", 8'h02, rdat[7:0])
    cmd(bhs_pkg::CMD_GET_MODE, 24'h000000, 24'h000000, 8'h00);
    `CHK("mode", bhs_pkg::MODE_MAIN, rdat[0])
    // Enable low over one full half period must hold the heartbeat still.
    rdat[0] = hb;
    ce = 1'b0;
    repeat (10) @(negedge clk_sys);
    `CHK("freeze", rdat[0], hb)
    ce = 1'b1;
    hb_half(10);
    err_det = 1'b1;
    hb_half(4);
    err_det = 1'b0;
    cmd(bhs_pkg::CMD_ERASE, 24'h012345, 24'h000000, 8'h00);
    `CHK("locked", 1'b1, rerr)
    cmd(bhs_pkg::CMD_DBG_ROUTE, 24'h000000, 24'h000000, 8'h01);
    `CHK("usb", 1'b1, usb)
    cmd(bhs_pkg::CMD_SWITCH_MODE, 24'h000000, 24'h000000, 8'h00);
    cmd(bhs_pkg::CMD_GET_MODE, 24'h000000, 24'h000000, 8'h00);
    `CHK("mode", bhs_pkg::MODE_LOADER, rdat[0])
    cmd(bhs_pkg::CMD_UNLOCK, 24'h000000, 24'h000000, 8'h00);
    cmd(bhs_pkg::CMD_ERASE, 24'h012345, 24'h000000, 8'h00);
    `CHK("erase", 1'b0, rerr)
    `CHK("sector", 24'h012345 & bhs_pkg::SECTOR_MASK, er_addr)
    cmd(bhs_pkg::CMD_CHECKSUM, 24'h000010, 24'h000003, 8'h00);
    `CHK("sum", 32'h00000033, rdat)
    cmd(bhs_pkg::CMD_PROGRAM, 24'h000020, 24'h000000, 8'h5A);
    `CHK("prog", 1'b0, rerr)
    `CHK("wdata", 8'h5A, f_wdata)
    cmd(bhs_pkg::CMD_LOCK, 24'h000000, 24'h000000, 8'h00);
    cmd(bhs_pkg::CMD_PROGRAM, 24'h000020, 24'h000000, 8'h5A);
    `CHK("relock", 1'b1, rerr)
    exc_case();
    boot(1'b0, 1'b1);
    cmd(bhs_pkg::CMD_GET_MODE, 24'h000000, 24'h000000, 8'h00);
    `CHK("hold", bhs_pkg::MODE_LOADER, rdat[0])
    boot(1'b1, 1'b0);
    `CHK("fault", 1'b1, led)
    cmd(bhs_pkg::CMD_SWITCH_MODE, 24'h000000, 24'h000000, 8'h01);
    `CHK("no_image", 1'b1, rerr)
    end_sim();
  end
  // The whole run needs a few hundred cycles; this cuts off a hang.
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule : bhs_top_tb_top
